// ===== cadc_pkg.sv
package cadc_pkg;

    // ------------------------------------------------------------
    // widths and codes
    // ------------------------------------------------------------
    localparam int DATA_W = 24;
    localparam int GAIN_W = 16;
    localparam int SEL_W = 3;
    localparam int ACC_W = 42;
    localparam int OSR_MIN_LOG2 = 6;
    localparam logic [DATA_W-1:0] POS_FS = 24'h7FFFFF;
    localparam logic [DATA_W-1:0] NEG_FS = 24'h800000;
    localparam logic [DATA_W-1:0] OFFSET_RST = 24'h000000;
    localparam logic [GAIN_W-1:0] GAIN_RST = 16'h0000;
    localparam logic [SEL_W-1:0] SEL_RST = 3'h0;
    localparam int CAL_SHIFT = 16;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0] offset;
        logic [GAIN_W-1:0] gain;
    } cadc_cal_t;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
    } cadc_sample_t;

endpackage : cadc_pkg

// ===== cadc_calib.sv
`timescale 1ns/1ps
`default_nettype none
module cadc_calib
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic in_valid,
    input wire logic signed [cadc_pkg::DATA_W-1:0] in_data,
    input wire cadc_pkg::cadc_cal_t cal,
    output cadc_pkg::cadc_sample_t out
);
    localparam int DW = cadc_pkg::DATA_W;
    localparam int GW = cadc_pkg::GAIN_W;
    localparam int PW = DW + 1 + GW + 2;

    cadc_pkg::cadc_sample_t out_ff;
    cadc_pkg::cadc_sample_t nxt_out;
    logic signed [DW:0] diff;
    logic signed [GW+1:0] factor;
    logic signed [PW-1:0] prod;
    logic signed [PW-1:0] rounded;
    logic signed [PW-1:0] scaled;

    always_comb
    begin
        // offset first, then gain
        diff = (DW+1)'(in_data) - (DW+1)'($signed(cal.offset));
        // factor is 1 + g/2^16, kept scaled by 2^16
        factor = (GW+2)'(18'sh10000) + (GW+2)'($signed(cal.gain));
        prod = PW'(diff) * PW'(factor);
        // round half up to the output lsb
        rounded = prod + PW'(18'sh08000);
        scaled = rounded >>> cadc_pkg::CAL_SHIFT;
        nxt_out = out_ff;
        nxt_out.valid = in_valid;
        if (in_valid)
        begin
            // clip to full scale, two's complement
            if (scaled > PW'($signed(cadc_pkg::POS_FS)))
                nxt_out.data = cadc_pkg::POS_FS;
            else if (scaled < PW'($signed(cadc_pkg::NEG_FS)))
                nxt_out.data = cadc_pkg::NEG_FS;
            else
                nxt_out.data = scaled[DW-1:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            out_ff <= '0;
        else if (ce)
            out_ff <= nxt_out;
    end

    assign out = out_ff;
endmodule : cadc_calib
`default_nettype wire

// ===== cadc_decim.sv
`timescale 1ns/1ps
`default_nettype none
module cadc_decim
#(
    parameter int NCH = 2
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [NCH-1:0] mod_bit,
    input wire logic [cadc_pkg::SEL_W-1:0] decim_ratio_sel,
    input wire logic [cadc_pkg::DATA_W-1:0] offset_corr_upper_reg,
    input wire logic [cadc_pkg::DATA_W-1:0] offset_corr_lower_reg,
    input wire logic [cadc_pkg::GAIN_W-1:0] gain_corr_value [NCH],
    output logic mod_clk,
    output logic [cadc_pkg::DATA_W-1:0] sample_data [NCH],
    output logic [NCH-1:0] sample_valid
);
    localparam int AW = cadc_pkg::ACC_W;
    localparam int DW = cadc_pkg::DATA_W;
    localparam int SW = cadc_pkg::SEL_W;
    localparam int CW = 14;

    // ------------------------------------------------------------
    // modulator clock and decimation counter
    // ------------------------------------------------------------
    logic mod_ff;
    logic nxt_mod;
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic [SW-1:0] sel_ff;
    logic [SW-1:0] nxt_sel;
    logic [CW-1:0] osr_last;
    logic mod_tick;
    logic dec_tick;

    always_comb
    begin
        // divide by two gives a 50% modulator clock
        nxt_mod = ~mod_ff;
        mod_tick = mod_ff;
        // ratio = 64 << code
        osr_last = CW'((32'd1 << (cadc_pkg::OSR_MIN_LOG2 + int'(sel_ff))) - 1);
        dec_tick = mod_tick && (cnt_ff == osr_last);
        nxt_cnt = cnt_ff;
        nxt_sel = sel_ff;
        if (mod_tick)
            nxt_cnt = dec_tick ? '0 : cnt_ff + CW'(1);
        // ratio change only takes effect on a sample boundary
        if (dec_tick || cnt_ff == '0)
            nxt_sel = decim_ratio_sel;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mod_ff <= 1'b0;
            cnt_ff <= '0;
            sel_ff <= cadc_pkg::SEL_RST;
        end
        else if (ce)
        begin
            mod_ff <= nxt_mod;
            cnt_ff <= nxt_cnt;
            sel_ff <= nxt_sel;
        end
    end

    assign mod_clk = mod_ff;

    // ------------------------------------------------------------
    // per channel sinc3 and calibration
    // ------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++)
        begin : g_ch
            logic [AW-1:0] i1_ff;
            logic [AW-1:0] i2_ff;
            logic [AW-1:0] i3_ff;
            logic [AW-1:0] d1_ff;
            logic [AW-1:0] d2_ff;
            logic [AW-1:0] d3_ff;
            logic [AW-1:0] nxt_i1;
            logic [AW-1:0] nxt_i2;
            logic [AW-1:0] nxt_i3;
            logic [AW-1:0] nxt_d1;
            logic [AW-1:0] nxt_d2;
            logic [AW-1:0] nxt_d3;
            logic [AW-1:0] c1;
            logic [AW-1:0] c2;
            logic [AW-1:0] c3;
            logic [DW-1:0] fil_ff;
            logic [DW-1:0] nxt_fil;
            logic vld_ff;
            logic nxt_vld;
            logic [AW-1:0] x;
            logic [AW-1:0] aligned;
            logic pos_ovf;
            cadc_pkg::cadc_cal_t cal;
            cadc_pkg::cadc_sample_t res;

            // ------------------------------------------------------------
            // sinc3 integrators and combs
            // ------------------------------------------------------------

            always_comb
            begin
                // bit 1 -> +1, bit 0 -> -1
                x = mod_bit[ch] ? AW'(1) : {AW{1'b1}};
                nxt_i1 = i1_ff;
                nxt_i2 = i2_ff;
                nxt_i3 = i3_ff;
                nxt_d1 = d1_ff;
                nxt_d2 = d2_ff;
                nxt_d3 = d3_ff;
                c1 = i3_ff - d1_ff;
                c2 = c1 - d2_ff;
                c3 = c2 - d3_ff;
                // cic form of the sinc3 filter
                if (mod_tick)
                begin
                    nxt_i1 = i1_ff + x;
                    nxt_i2 = i2_ff + i1_ff;
                    nxt_i3 = i3_ff + i2_ff;
                end
                if (dec_tick)
                begin
                    nxt_d1 = i3_ff;
                    nxt_d2 = c1;
                    nxt_d3 = c2;
                end
                // full scale is +/-osr^3; keep the top 24 bits
                aligned = AW'($signed(c3) <<< (AW - 1 - 3 * (cadc_pkg::OSR_MIN_LOG2
                          + int'(sel_ff))));
                // a stream of ones gives +osr^3, which the shift would wrap
                // to the most negative code, so pin it to the top
                pos_ovf = !c3[AW-1] && aligned[AW-1];
                if (pos_ovf)
                begin
                    aligned = {1'b0, {(AW-1){1'b1}}};
                end
                nxt_fil = dec_tick ? aligned[AW-1 -: DW] : fil_ff;
                nxt_vld = dec_tick;
            end

            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    i1_ff <= '0;
                    i2_ff <= '0;
                    i3_ff <= '0;
                    d1_ff <= '0;
                    d2_ff <= '0;
                    d3_ff <= '0;
                    fil_ff <= '0;
                    vld_ff <= 1'b0;
                end
                else if (ce)
                begin
                    i1_ff <= nxt_i1;
                    i2_ff <= nxt_i2;
                    i3_ff <= nxt_i3;
                    d1_ff <= nxt_d1;
                    d2_ff <= nxt_d2;
                    d3_ff <= nxt_d3;
                    fil_ff <= nxt_fil;
                    vld_ff <= nxt_vld;
                end
            end

            // ------------------------------------------------------------
            // calibration and output
            // ------------------------------------------------------------

            // upper port carries bits 23:12, lower 11:0
            assign cal = {offset_corr_upper_reg[DW/2-1:0],
                          offset_corr_lower_reg[DW/2-1:0],
                          gain_corr_value[ch]};

            cadc_calib u_cal
            (
                .clk(clk),
                .rst(rst),
                .ce(ce),
                .in_valid(vld_ff & ce),
                .in_data(fil_ff),
                .cal(cal),
                .out(res)
            );

            // every sample goes to the framer
            assign sample_data[ch] = res.data;
            assign sample_valid[ch] = res.valid;
        end
    endgenerate
endmodule : cadc_decim
`default_nettype wire

// ===== cadc_props.sv
`timescale 1ns/1ps
`default_nettype none
module cadc_props
#(
    parameter int NCH = 2
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic mod_clk,
    input wire logic [cadc_pkg::DATA_W-1:0] sample_data [NCH],
    input wire logic [NCH-1:0] sample_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_quiet0; !sample_valid[0] [*8]; endsequence
    sequence s_quiet1; !sample_valid[1] [*8]; endsequence
    chk_mod_toggle:
        assert property (ce |=> mod_clk != $past(mod_clk)) else $error("mod clock stuck");
    chk_freeze_hold:
        assert property (!ce |=> $stable(mod_clk) && $stable(sample_valid)) else $error("ce ignored");
    chk_valid_quiet0:
        assert property (sample_valid[0] && ce |=> s_quiet0) else $error("valid 0 not a pulse");
    chk_valid_quiet1:
        assert property (sample_valid[1] && ce |=> s_quiet1) else $error("valid 1 not a pulse");
    chk_chan_sync:
        assert property (sample_valid[0] == sample_valid[1]) else $error("channels out of step");
    chk_data_hold:
        assert property (sample_valid == 2'h0 |-> $stable(sample_data[0]) && $stable(sample_data[1]))
            else $error("data moved without valid");
    chk_valid_phase:
        assert property (sample_valid[0] |-> mod_clk) else $error("valid off phase");
    chk_reset_out:
        assert property ($fell(rst) |-> !mod_clk && sample_valid == 2'h0 && sample_data[0] == 24'h0)
            else $error("bad reset outputs");
endmodule : cadc_props
bind cadc_decim cadc_props #(.NCH(NCH)) u_props (.clk(clk), .rst(rst), .ce(ce),
    .mod_clk(mod_clk), .sample_data(sample_data), .sample_valid(sample_valid));
`default_nettype wire

// ===== cadc_mod_model.sv
`timescale 1ns/1ps
`default_nettype none
// first-order modulator stand-in, bit density follows lvl
module cadc_mod_model
(
    input wire logic clk,
    input wire logic mod_clk,
    input wire logic signed [16:0] lvl,
    output logic bit_o
);
    logic signed [18:0] acc_ff = 19'sh0;
    assign bit_o = !acc_ff[18];
    always_ff @(posedge clk)
        if (mod_clk)
            acc_ff <= acc_ff + lvl - (bit_o ? 19'sh8000 : -19'sh8000);
endmodule : cadc_mod_model
`default_nettype wire

// ===== cadc_decim_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin errors++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module cadc_decim_tb_top;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic ce = 1'h1;
    logic [2:0] sel = 3'h0;
    logic [23:0] up = 24'h0;
    logic [23:0] lo = 24'h0;
    logic [15:0] gain [2] = '{16'h0, 16'h0};
    logic signed [16:0] lvl = 17'h0;
    wire [1:0] mbit;
    logic [1:0] vld;
    logic mclk;
    logic [23:0] dat [2];
    logic [31:0] seed = 32'h1664;
    int errors = 0;
    int num_checks = 0;
    int cyc = 0;
    always #4 clk = ~clk;
    cadc_decim dut (.clk(clk), .rst(rst), .ce(ce), .mod_bit(mbit), .decim_ratio_sel(sel),
        .offset_corr_upper_reg(up), .offset_corr_lower_reg(lo), .gain_corr_value(gain),
        .mod_clk(mclk), .sample_data(dat), .sample_valid(vld));
    cadc_mod_model m0 (.clk(clk), .mod_clk(mclk), .lvl(lvl), .bit_o(mbit[0]));
    cadc_mod_model m1 (.clk(clk), .mod_clk(mclk), .lvl(lvl), .bit_o(mbit[1]));
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 100000)
        begin
            errors++;
            results();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [23:0] calc(longint x, longint off, longint g);
        longint r;
        r = ((x - off) * (65536 + g) + 32768) >>> 16;
        return (r > 8388607) ? 24'h7FFFFF : (r < -8388608) ? 24'h800000 : r[23:0];
    endfunction : calc
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results
    task automatic wait_v(output int n);
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (vld[0] !== 1'h1);
    endtask : wait_v
    task automatic cal(logic signed [16:0] l, logic [23:0] off,
        logic [15:0] g0, logic [15:0] g1);
        logic [31:0] r;
        logic [23:0] e;
        longint d;
        int n;
        r = rnd();
        lvl = l;
        up = {r[11:0], off[23:12]};
        lo = {r[23:12], off[11:0]};
        gain = '{g0, g1};
        repeat (4) wait_v(n);
        for (int i = 0; i < 2; i++)
        begin
            e = calc((l == 17'h08000) ? 8388607 : l * 256, $signed(off), $signed(gain[i]));
            d = $signed(dat[i]) - $signed(e);
            if (l == 17'h08000 || l == 17'h18000)
                `CHK("cal", e, dat[i])
            else
                `CHK("near", 1'h1, d < 524288 && d > -524288)
        end
        $display("cal test done");
    endtask : cal
    initial
    begin
        logic [31:0] r;
        logic [31:0] q;
        int n;
        repeat (10) @(negedge clk);
        rst = 1'h0;
        cal(17'h08000, 24'h0, 16'h0, 16'h0);
        cal(17'h18000, 24'h0, 16'h8000, 16'h0);
        cal(17'h08000, 24'h400000, 16'h7FFF, 16'hFFFF);
        cal(17'h18000, 24'h7FFFFF, 16'h0001, 16'h0);
        cal(17'h08000, 24'h800000, 16'h0, 16'h8000);
        cal(17'h04000, 24'h0, 16'h0, 16'h0);
        cal(17'h00000, 24'h000010, 16'h0, 16'h0);
        repeat (6)
        begin
            r = rnd();
            q = rnd();
            cal({r[31], r[31], r[14:0]}, q[23:0], r[30:15], q[31:16]);
        end
        repeat (5) @(negedge clk);
        ce = 1'h0;
        repeat (37) @(negedge clk);
        ce = 1'h1;
        wait_v(n);
        `CHK("freeze", 123, n)
        $display("freeze test done");
        rst = 1'h1;
        repeat (10) @(negedge clk);
        rst = 1'h0;
        cal(17'h18000, 24'h000123, 16'h1234, 16'hF000);
        for (int c = 0; c < 8; c++)
        begin
            sel = c[2:0];
            wait_v(n);
            wait_v(n);
            `CHK("period", 128 << c, n)
        end
        $display("period test done");
        results();
    end
endmodule : cadc_decim_tb_top
`default_nettype wire
